/* File: hdl/dpc_top.sv */
// Dual potentiometer control: serial slave, registers and power-up recall.
`timescale 1ns/1ps
// Functional notes
// - With volatile-only clear, stored writes also update live position.
// - With volatile-only set, only live positions are reachable.
// - Shutoff bit low shuts down both pots; high runs them.
// - Busy flag reads one during stored write; bus cannot write it.
// - While busy, live and control writes are ignored.
// - At power-up stored values load into live positions.
// - Live positions are 8 bits; 0 low terminal, 255 high.
// - Low three address bits come from strap pins.
// - Start is data falling with clock high; address follows.
// - Address byte arrives MSB first, direction bit last.
// - General call is not acknowledged; wait for next start.
// - Own address acknowledged by holding data low on ninth clock.
// - Writes use direction low; each data byte is acknowledged.
// - Only whole acknowledged bytes act; partial bytes dropped.
// - Data change during clock high is start or stop.
// - Stop is data rising with clock high; return to idle.
// - Any number of bytes, each followed by one ack bit.
// - Successive data bytes go to consecutive registers.
// - Transmitter releases data after eighth bit for the ack.
// - Ack low before clock rises and through the high phase.
// - Data pin only pulled low, never driven high.
// - Control register resets to 0x40.
// - Busy holds for the 20 ms stored write time.
// - Wiper takes new value within 600 ns of last bit.
// - Recall finishes and bus stands by within 100 us.
module dpc_top
  import dpc_pkg::*;
#(
  parameter int NVW_CYCLES = DPC_NVW_CYCLES
)
(
  input  wire logic       clk,
  input  wire logic       nrst,
  input  wire logic       scl,
  input  wire logic       sda_i,
  output logic            sda_o,
  output logic            sda_oe_n,
  input  wire logic       addr_strap_0,
  input  wire logic       addr_strap_1,
  input  wire logic       addr_strap_2,
  output logic [7:0]      pot_a_live_position,
  output logic [7:0]      pot_b_live_position,
  output logic            pot_a_shutdown,
  output logic            pot_b_shutdown,
  output logic [7:0]      control_reg,
  output logic            ready
);

  //////////////////////////////////////////////////////////////////////////
  logic [2:0] strap_m_ff;
  logic [2:0] strap_ff;
  logic       byte_tgl;
  logic [7:0] byte_data;
  logic       byte_first;
  logic [2:0] tgl_sync_ff;
  logic       byte_evt;
  logic [7:0] ptr_ff;
  logic       vol_ff;
  logic       pot_shutoff_n_n_ff;
  logic       busy_ff;
  logic [24:0] nvw_cnt_ff;
  logic [7:0] live_a_ff;
  logic [7:0] live_b_ff;
  logic       nv_we;
  logic [7:0] nv_rd_a;
  logic [7:0] nv_rd_b;
  logic [13:0] pwr_cnt_ff;
  dpc_pwr_t   pwr_ff;
  logic       run;
  logic       wr_ctrl;
  logic       wr_live;
  logic       wr_pot_a;
  logic       wr_pot_b;

  // Address straps come from pins, so two stages first.
  always_ff @(posedge clk or negedge nrst)
  begin
    if (!nrst)
    begin
      strap_m_ff <= 3'h0;
      strap_ff   <= 3'h0;
    end
    else
    begin
      strap_m_ff <= {addr_strap_2, addr_strap_1, addr_strap_0};
      strap_ff   <= strap_m_ff;
    end
  end

  // Serial front end runs on the bus clock itself.
  dpc_i2c_rx u_rx
  (
    .scl         (scl),
    .nrst        (nrst),
    .sda_i       (sda_i),
    .strap       (strap_ff),
    .sda_o       (sda_o),
    .sda_oe_n    (sda_oe_n),
    .byte_tgl_ff (byte_tgl),
    .byte_ff     (byte_data),
    .first_ff    (byte_first)
  );

  //////////////////////////////////////////////////////////////////////////
  // Byte event crosses as a toggle; data is stable until the next byte.
  always_ff @(posedge clk or negedge nrst)
  begin
    if (!nrst)
      tgl_sync_ff <= 3'h0;
    else
      tgl_sync_ff <= {tgl_sync_ff[1:0], byte_tgl};
  end

  // Event seen about 2 clocks (16 ns) after the byte lands.
  assign byte_evt = tgl_sync_ff[2] ^ tgl_sync_ff[1];
  assign run      = pwr_ff == DPC_PWR_RUN;

  // Pointer decode for the registers that also have a stored cell.
  function automatic logic dpc_is_pot(input logic [7:0] p);
    return p == DPC_REG_POT_A || p == DPC_REG_POT_B;
  endfunction

  // Data write qualifiers for the current pointer. A busy stored write
  // blocks every data write, so cells and wipers cannot drift apart.
  assign wr_live  = run && byte_evt && !byte_first && !busy_ff;
  assign wr_ctrl  = wr_live && ptr_ff == DPC_REG_CTRL;
  assign wr_pot_a = wr_live && ptr_ff == DPC_REG_POT_A;
  assign wr_pot_b = wr_live && ptr_ff == DPC_REG_POT_B;
  assign nv_we    = wr_live && !vol_ff && dpc_is_pot(ptr_ff);

  // Pointer: first byte loads it, each later byte steps it.
  always_ff @(posedge clk or negedge nrst)
  begin
    if (!nrst)
      ptr_ff <= 8'h00;
    else if (byte_evt && byte_first)
      ptr_ff <= byte_data;
    else if (byte_evt)
      ptr_ff <= ptr_ff + 8'h01;
  end

  // Control fields; busy bit is never written by the bus.
  always_ff @(posedge clk or negedge nrst)
  begin
    if (!nrst)
    begin
      vol_ff    <= DPC_CTRL_RESET[DPC_CTRL_VOL_BIT];
      pot_shutoff_n_n_ff <= DPC_CTRL_RESET[DPC_CTRL_POT_SHUTOFF_N_BIT];
    end
    else if (wr_ctrl)
    begin
      vol_ff    <= byte_data[DPC_CTRL_VOL_BIT];
      pot_shutoff_n_n_ff <= byte_data[DPC_CTRL_POT_SHUTOFF_N_BIT];
    end
  end

  // Busy timer for a stored write.
  always_ff @(posedge clk or negedge nrst)
  begin
    if (!nrst)
    begin
      busy_ff    <= 1'b0;
      nvw_cnt_ff <= 25'h0;
    end
    else if (nv_we)
    begin
      busy_ff    <= 1'b1;
      nvw_cnt_ff <= 25'(NVW_CYCLES - 1);
    end
    else if (busy_ff)
    begin
      if (nvw_cnt_ff == 25'h0)
        busy_ff <= 1'b0;
      else
        nvw_cnt_ff <= nvw_cnt_ff - 25'h1;
    end
  end

  // Stored cells; untouched in volatile-only mode.
  dpc_nv_store #(.WIDTH(8)) u_nv
  (
    .clk     (clk),
    .nrst    (nrst),
    .wr_en   (nv_we),
    .wr_sel  (ptr_ff[0]),
    .wr_data (byte_data),
    .rd_a    (nv_rd_a),
    .rd_b    (nv_rd_b)
  );

  //////////////////////////////////////////////////////////////////////////
  // Power-up recall: wait for read data, load wipers, then serve.
  always_ff @(posedge clk or negedge nrst)
  begin
    if (!nrst)
    begin
      pwr_ff     <= DPC_PWR_RECALL;
      pwr_cnt_ff <= 14'h0;
    end
    else
    begin
      unique case (pwr_ff)
        DPC_PWR_RECALL:
        begin
          pwr_cnt_ff <= pwr_cnt_ff + 14'h1;
          if (pwr_cnt_ff == 14'h3) // Well inside the recall limit.
            pwr_ff <= DPC_PWR_LOAD;
        end
        DPC_PWR_LOAD:
          pwr_ff <= DPC_PWR_RUN;
        DPC_PWR_RUN:
          pwr_ff <= DPC_PWR_RUN;
        default:
          pwr_ff <= DPC_PWR_RECALL;
      endcase
    end
  end

  // Live wiper codes, 8 bits each.
  always_ff @(posedge clk or negedge nrst)
  begin
    if (!nrst)
    begin
      live_a_ff <= 8'h00;
      live_b_ff <= 8'h00;
    end
    else if (pwr_ff == DPC_PWR_LOAD)
    begin
      live_a_ff <= nv_rd_a;
      live_b_ff <= nv_rd_b;
    end
    else if (wr_pot_a)
      live_a_ff <= byte_data;
    else if (wr_pot_b)
      live_b_ff <= byte_data;
  end

  // Outputs; shutdown follows the shutoff bit.
  assign pot_a_live_position = live_a_ff;
  assign pot_b_live_position = live_b_ff;
  assign pot_a_shutdown      = ~pot_shutoff_n_n_ff;
  assign pot_b_shutdown      = ~pot_shutoff_n_n_ff;
  assign control_reg         = {vol_ff, pot_shutoff_n_n_ff, busy_ff, 5'h00};
  assign ready               = run;

endmodule

/* File: shared/dpc_pkg.sv */
// Shared constants and types for the dual potentiometer control block.
package dpc_pkg;

  // Bus address: fixed prefix plus three strap bits; value is arbitrary.
  localparam logic [3:0] DPC_DEV_PREFIX = 4'h5;
  localparam logic [6:0] DPC_GEN_CALL   = 7'h00;

  // Register map.
  localparam logic [7:0] DPC_REG_POT_A = 8'h00;
  localparam logic [7:0] DPC_REG_POT_B = 8'h01;
  localparam logic [7:0] DPC_REG_CTRL  = 8'h10;

  // Control register fields and reset value.
  localparam int         DPC_CTRL_VOL_BIT  = 7;
  localparam int         DPC_CTRL_POT_SHUTOFF_N_BIT = 6;
  localparam int         DPC_CTRL_BUSY_BIT = 5;
  localparam logic [7:0] DPC_CTRL_RESET    = 8'h40;

  // Stored value used before any programming.
  localparam logic [7:0] DPC_INIT_DEFAULT = 8'h80;

  // Timing at the 125 MHz system clock.
  localparam int DPC_CLK_MHZ     = 125;
  localparam int DPC_NVW_MS      = 20;
  localparam int DPC_NVW_CYCLES  = DPC_NVW_MS * 1000 * DPC_CLK_MHZ;
  localparam int DPC_RECALL_US   = 100;
  localparam int DPC_RECALL_CYC  = DPC_RECALL_US * DPC_CLK_MHZ;
  localparam int DPC_WIPER_NS    = 600;
  localparam int DPC_WIPER_CYC   = (DPC_WIPER_NS * DPC_CLK_MHZ) / 1000;

  // Power-up sequence states.
  typedef enum logic [1:0]
  {
    DPC_PWR_RECALL = 2'b00,
    DPC_PWR_LOAD   = 2'b01,
    DPC_PWR_RUN    = 2'b10
  } dpc_pwr_t;

endpackage

/* File: hdl/dpc_nv_store.sv */
// Two-word non-volatile store model with registered read data.
`timescale 1ns/1ps
module dpc_nv_store
  import dpc_pkg::*;
#(
  parameter int WIDTH = 8
)
(
  input  wire logic             clk,
  input  wire logic             nrst,
  input  wire logic             wr_en,
  input  wire logic             wr_sel,
  input  wire logic [WIDTH-1:0] wr_data,
  output logic      [WIDTH-1:0] rd_a,
  output logic      [WIDTH-1:0] rd_b
);

  // Cells are not cleared by reset: a power cycle must find the last
  // programmed value again, so the array starts from the factory value only.
  logic [WIDTH-1:0] mem_ff [2] = '{WIDTH'(DPC_INIT_DEFAULT),
                                   WIDTH'(DPC_INIT_DEFAULT)};

  // Cell array; each cell holds its programmed value.
  always_ff @(posedge clk)
  begin
    if (wr_en)
      mem_ff[wr_sel] <= wr_data;
  end

  // Read data leaves through registers.
  always_ff @(posedge clk or negedge nrst)
  begin
    if (!nrst)
    begin
      rd_a <= '0;
      rd_b <= '0;
    end
    else
    begin
      rd_a <= mem_ff[0];
      rd_b <= mem_ff[1];
    end
  end

endmodule

/* File: hdl/dpc_i2c_rx.sv */
// Bus-facing receiver on the serial clock: start, stop, bytes and acknowledge.
`timescale 1ns/1ps
module dpc_i2c_rx
  import dpc_pkg::*;
(
  input  wire logic       scl,
  input  wire logic       nrst,
  input  wire logic       sda_i,
  input  wire logic [2:0] strap,
  output logic            sda_o,
  output logic            sda_oe_n,
  output logic            byte_tgl_ff,
  output logic [7:0]      byte_ff,
  output logic            first_ff
);

  logic       start_tgl_ff;
  logic       stop_tgl_ff;
  logic       start_seen_ff;
  logic       stop_seen_ff;
  logic       active_ff;
  logic       addr_phase_ff;
  logic [3:0] bit_cnt_ff;
  logic [7:0] shift_ff;
  logic       ack_ff;
  logic       data_first_ff;
  logic [2:0] strap_m_ff;
  logic [2:0] strap_s_ff;

  // Start: data falls while clock high.
  always_ff @(negedge sda_i or negedge nrst)
  begin
    if (!nrst)
      start_tgl_ff <= 1'b0;
    else if (scl)
      start_tgl_ff <= ~start_tgl_ff;
  end

  // Stop: data rises while clock high.
  always_ff @(posedge sda_i or negedge nrst)
  begin
    if (!nrst)
      stop_tgl_ff <= 1'b0;
    else if (scl)
      stop_tgl_ff <= ~stop_tgl_ff;
  end

  // Conditions are consumed at the next clock edge of the frame.
  always_ff @(posedge scl or negedge nrst)
  begin
    if (!nrst)
    begin
      start_seen_ff <= 1'b0;
      stop_seen_ff  <= 1'b0;
    end
    else
    begin
      start_seen_ff <= start_tgl_ff;
      stop_seen_ff  <= stop_tgl_ff;
    end
  end

  // Bit sampling on rising clock, MSB first; partial bytes drop.
  always_ff @(posedge scl or negedge nrst)
  begin
    if (!nrst)
    begin
      active_ff     <= 1'b0;
      addr_phase_ff <= 1'b0;
      bit_cnt_ff    <= 4'h0;
      shift_ff      <= 8'h00;
      byte_tgl_ff   <= 1'b0;
      byte_ff       <= 8'h00;
      first_ff      <= 1'b0;
      data_first_ff <= 1'b0;
    end
    else if (start_seen_ff != start_tgl_ff)
    begin
      active_ff     <= 1'b1;
      addr_phase_ff <= 1'b1;
      bit_cnt_ff    <= 4'h1;
      shift_ff      <= {7'h00, sda_i};
    end
    else if (stop_seen_ff != stop_tgl_ff)
      active_ff <= 1'b0;
    else if (active_ff)
    begin
      if (bit_cnt_ff == 4'h8)
      begin
        bit_cnt_ff <= 4'h0;
        if (addr_phase_ff)
        begin
          addr_phase_ff <= 1'b0;
          data_first_ff <= 1'b1;
          // Unmatched, general call or read: idle till next start.
          if (!ack_ff)
            active_ff <= 1'b0;
        end
        else if (ack_ff)
        begin
          // Whole acknowledged byte handed over.
          byte_tgl_ff   <= ~byte_tgl_ff;
          byte_ff       <= shift_ff;
          first_ff      <= data_first_ff;
          data_first_ff <= 1'b0;
        end
      end
      else
      begin
        shift_ff   <= {shift_ff[6:0], sda_i};
        bit_cnt_ff <= bit_cnt_ff + 4'h1;
      end
    end
  end

  // Straps come from the system clock side; two serial clock stages
  // settle them long before the eighth address bit is compared.
  always_ff @(posedge scl or negedge nrst)
  begin
    if (!nrst)
    begin
      strap_m_ff <= 3'h0;
      strap_s_ff <= 3'h0;
    end
    else
    begin
      strap_m_ff <= strap;
      strap_s_ff <= strap_m_ff;
    end
  end

  // Acknowledge drive set on the falling edge after bit eight.
  always_ff @(negedge scl or negedge nrst)
  begin
    if (!nrst)
      ack_ff <= 1'b0;
    else if (active_ff && bit_cnt_ff == 4'h8)
    begin
      if (addr_phase_ff)
        ack_ff <= shift_ff[7:1] == {DPC_DEV_PREFIX, strap_s_ff}
                  && shift_ff[7:1] != DPC_GEN_CALL && !shift_ff[0];
      else
        ack_ff <= 1'b1;
    end
    else
      ack_ff <= 1'b0; // Line released after the ack bit.
  end

  // Open drain: only ever low, enable low while driving.
  assign sda_o    = 1'b0;
  assign sda_oe_n = ~ack_ff;

endmodule

/* File: verif/dpc_top_monitor.sv */
// Port-level checks on the potentiometer control top.
`timescale 1ns/1ps
module dpc_top_monitor
  import dpc_pkg::*;
#(
  parameter int NVW_CYCLES = 200
)
(
  input wire logic       clk,
  input wire logic       nrst,
  input wire logic       scl,
  input wire logic       sda_o,
  input wire logic       sda_oe_n,
  input wire logic [7:0] pot_b_live_position,
  input wire logic       pot_a_shutdown,
  input wire logic       pot_b_shutdown,
  input wire logic [7:0] control_reg,
  input wire logic       ready
);
  int busy_cnt_ff;

  // Counts busy cycles; the stored write must hold the flag its full time.
  always_ff @(posedge clk or negedge nrst)
  begin
    if (!nrst)
      busy_cnt_ff <= 0;
    else if (control_reg[5])
      busy_cnt_ff <= busy_cnt_ff + 1;
    else
      busy_cnt_ff <= 0;
  end

  default clocking cb @(posedge clk); endclocking
  default disable iff (!nrst);
  //////////////////////////////////////////////////////////////

  a_data_low_only: assert property (sda_o == 1'b0)
    else $error("data pin driven high");
  a_shut_both: assert property (pot_a_shutdown == !control_reg[6]
    && pot_b_shutdown == !control_reg[6]) else $error("shutdown wrong");
  a_ctrl_zero: assert property (control_reg[4:0] == 5'h00)
    else $error("control low bits set");
  a_ctrl_reset: assert property ($rose(nrst) |->
    control_reg == DPC_CTRL_RESET) else $error("control reset value");
  a_recall_bound: assert property ($rose(nrst) |-> ##[1:1000] ready)
    else $error("recall too slow");
  a_quiet_unready: assert property (!ready |-> sda_oe_n)
    else $error("ack before ready");
  a_busy_time: assert property ($fell(control_reg[5]) |->
    busy_cnt_ff >= NVW_CYCLES - 2 && busy_cnt_ff <= NVW_CYCLES + 2)
    else $error("busy time wrong");
  a_busy_freeze: assert property ($past(control_reg[5], 4)
    && control_reg[5] |-> $stable(pot_b_live_position)
    && $stable(control_reg[7:6])) else $error("write while busy");
  a_ack_steady: assert property (scl && $past(scl)
    |-> $stable(sda_oe_n)) else $error("ack moved in clock high");
endmodule

bind dpc_top dpc_top_monitor #(.NVW_CYCLES(NVW_CYCLES)) u_mon
(
  .clk(clk), .nrst(nrst), .scl(scl), .sda_o(sda_o),
  .sda_oe_n(sda_oe_n), .pot_b_live_position(pot_b_live_position),
  .pot_a_shutdown(pot_a_shutdown), .pot_b_shutdown(pot_b_shutdown),
  .control_reg(control_reg), .ready(ready)
);

/* File: verif/dpc_bus_master.sv */
// Serial bus master model; clock idles high between frames.
`timescale 1ns/1ps
module dpc_bus_master
(
  output logic      scl,
  output logic      sda_m,
  input  wire logic sda_w
);
  localparam int HALF = 15;

  // Both lines released so the bus starts idle.
  initial
  begin
    scl = 1'b1;
    sda_m = 1'b1;
  end
  //////////////////////////////////////////////////////////////

  // Data falls while the clock is high on an idle bus.
  task automatic start();
    sda_m = 1'b1;
    #HALF sda_m = 1'b0;
    #HALF scl = 1'b0;
  endtask

  // Data only moves while the clock is low, so it is steady when high.
  task automatic send_bit(input logic b);
    sda_m = b;
    #HALF scl = 1'b1;
    #HALF scl = 1'b0;
  endtask

  // MSB first, then the line is released for the receiver's ack.
  task automatic put(input logic [7:0] b, output logic ack);
    for (int i = 7; i >= 0; i--)
      send_bit(b[i]);
    sda_m = 1'b1;
    #HALF scl = 1'b1;
    #HALF ack = !sda_w;
    scl = 1'b0;
  endtask

  // Data rises while the clock is high; both lines then stay high.
  task automatic stop();
    sda_m = 1'b0;
    #HALF scl = 1'b1;
    #HALF sda_m = 1'b1;
    #HALF;
  endtask
endmodule

/* File: verif/test_dual_pot_i2c_control.sv */
// Self-checking bench for the dual potentiometer control block.
`timescale 1ns/1ps
module test_dual_pot_i2c_control;
  import dpc_pkg::*;
  localparam int NVW = 600;
  logic       clk, nrst, scl, sda_m, sda_w, sda_o, sda_oe_n;
  logic       shut_a, shut_b, ready, ack;
  logic [2:0] strap;
  logic [6:0] own;
  logic [7:0] pos_a, pos_b, ctrl;
  int         n_fail, total_checks;

  // Open-drain wire with a pull-up: anyone pulling low wins.
  assign sda_w = sda_m & (sda_oe_n | sda_o);

  dpc_top #(.NVW_CYCLES(NVW)) u_dut
  (
    .clk(clk), .nrst(nrst), .scl(scl), .sda_i(sda_w), .sda_o(sda_o),
    .sda_oe_n(sda_oe_n), .addr_strap_0(strap[0]),
    .addr_strap_1(strap[1]), .addr_strap_2(strap[2]),
    .pot_a_live_position(pos_a), .pot_b_live_position(pos_b),
    .pot_a_shutdown(shut_a), .pot_b_shutdown(shut_b),
    .control_reg(ctrl), .ready(ready)
  );
  dpc_bus_master u_mst (.scl(scl), .sda_m(sda_m), .sda_w(sda_w));

  initial clk = 1'b0;
  always #4 clk = ~clk;
  //////////////////////////////////////////////////////////////

  task automatic check(input logic [7:0] got, input logic [7:0] exp);
    total_checks++;
    if (got !== exp)
    begin
      n_fail++;
      $display("wrong value at %0t: got %h expected %h", $time, got, exp);
    end
  endtask

  task automatic stop_test();
    $display("checks %0d mismatches %0d", total_checks, n_fail);
    if (n_fail == 0 && total_checks > 0)
      $display("ALL CHECKS OK");
    else
      $display("CHECKS NOT OK");
    $finish;
  endtask

  // Reset, then a bounded wait for the power-up recall.
  task automatic do_reset();
    @(posedge clk) #1 nrst = 1'b0;
    repeat (2) @(posedge clk);
    #1 nrst = 1'b1;
    for (int i = 0; i < 1000 && ready !== 1'b1; i++)
      @(posedge clk);
    check({7'h00, ready}, 8'h01);
  endtask

  // One write frame; pointer and data only go if an ack of the address is expected (ea).
  task automatic xfer(input logic [6:0] a, input logic [7:0] p,
                      input logic [7:0] d0, input logic [7:0] d1,
                      input int n, input logic ea);
    u_mst.start();
    u_mst.put({a, 1'b0}, ack);
    check({7'h00, ack}, {7'h00, ea});
    if (ea)
    begin
      u_mst.put(p, ack);
      check({7'h00, ack}, 8'h01);
      for (int i = 0; i < n; i++)
      begin
        u_mst.put(i == 0 ? d0 : d1, ack);
        check({7'h00, ack}, 8'h01);
      end
    end
    u_mst.stop();
    repeat (20) @(posedge clk);
  endtask

  // Main sequence.
  initial
  begin
    n_fail = 0;
    total_checks = 0;
    nrst = 1'b0;
    strap = 3'h5;
    own = {DPC_DEV_PREFIX, 3'h5};
    do_reset();
    check(pos_a, DPC_INIT_DEFAULT);
    check(pos_b, DPC_INIT_DEFAULT);
    check(ctrl, DPC_CTRL_RESET);
    xfer(own ^ 7'h01, 8'h00, 8'h00, 8'h00, 0, 1'b0);
    xfer(DPC_GEN_CALL, 8'h00, 8'h00, 8'h00, 0, 1'b0);
    // A read request is not served, so it is not acknowledged.
    u_mst.start();
    u_mst.put({own, 1'b1}, ack);
    check({7'h00, ack}, 8'h00);
    u_mst.stop();
    xfer(own, DPC_REG_CTRL, 8'hc0, 8'h00, 1, 1'b1);
    check(ctrl, 8'hc0);
    xfer(own, DPC_REG_POT_A, 8'h12, 8'h34, 2, 1'b1);
    check(pos_a, 8'h12);
    check(pos_b, 8'h34);
    check(ctrl, 8'hc0);
    xfer(own, DPC_REG_CTRL, 8'h20, 8'h00, 1, 1'b1);
    check(ctrl, 8'h00);
    check({6'h00, shut_a, shut_b}, 8'h03);
    xfer(own, DPC_REG_CTRL, 8'h40, 8'h00, 1, 1'b1);
    check({6'h00, shut_a, shut_b}, 8'h00);
    // A byte cut short by a stop must not land.
    u_mst.start();
    u_mst.put({own, 1'b0}, ack);
    u_mst.put(DPC_REG_POT_A, ack);
    for (int i = 0; i < 4; i++)
      u_mst.send_bit(1'b0);
    u_mst.stop();
    repeat (20) @(posedge clk);
    check(pos_a, 8'h12);
    xfer(own, DPC_REG_POT_A, 8'h55, 8'h00, 1, 1'b1);
    check(pos_a, 8'h55);
    check(ctrl, 8'h60);
    xfer(own, DPC_REG_POT_B, 8'h66, 8'h00, 1, 1'b1);
    check(pos_b, 8'h34);
    xfer(own, DPC_REG_CTRL, 8'hc0, 8'h00, 1, 1'b1);
    check(ctrl, 8'h60);
    for (int i = 0; i < NVW + 200 && ctrl[5] !== 1'b0; i++)
      @(posedge clk);
    check(ctrl, 8'h40);
    // Power is cycled: the stored A value must come back, and B was never
    // programmed because its writes were volatile-only or blocked.
    do_reset();
    check(pos_a, 8'h55);
    check(pos_b, DPC_INIT_DEFAULT);
    check(ctrl, DPC_CTRL_RESET);
    stop_test();
  end

  // Watchdog, far beyond the roughly 12 microseconds the run needs.
  initial
  begin
    #200000;
    n_fail++;
    stop_test();
  end
endmodule
